/* File: include/srta_params.svh */
`ifndef SRTA_PARAMS_SVH
`define SRTA_PARAMS_SVH

// Pin function codes and enable levels of the trigger pins, leader select and leader timing.
`define SRTA_GPIO_FUNC_TRIG_IN  8'h21
`define SRTA_GPIO_FUNC_TRIG_OUT 8'h22
`define SRTA_OE_B_OFF           1'h1
`define SRTA_LEADER_ON          1'h1
`define SRTA_TIMING_SECOND_EDGE 1'h0

// Event start latency in SYSREF clock rising edges.
`define SRTA_EDGES_FIRST        2'h1
`define SRTA_EDGES_SECOND       2'h2

// SYSREF modes.
`define SRTA_MODE_CNT_REG       3'h0
`define SRTA_MODE_PP_REG        3'h1
`define SRTA_MODE_CONT_REG      3'h2
`define SRTA_MODE_CONT_GPIO     3'h3
`define SRTA_MODE_CNT_RISE      3'h4
`define SRTA_MODE_CNT_FALL      3'h5
`define SRTA_MODE_CONT_RISE     3'h6
`define SRTA_MODE_CONT_FALL     3'h7

// Default half periods of the internal clocks in system clock cycles.
`define SRTA_FB_HALF_DEF        16
`define SRTA_SR_HALF_DEF        8
`define SRTA_DC_HALF_DEF        2

// Clock indices inside the divider bank.
`define SRTA_IDX_FB             0
`define SRTA_IDX_SR             1
`define SRTA_IDX_DC             2

`endif

/* File: include/srta_pkg.sv */
package srta_pkg;

    typedef enum logic [1:0] {
        SRTA_IDLE,
        SRTA_WAIT,
        SRTA_RUN
    } srta_state_t;

    typedef struct packed {
        logic [2:0] sysrefMode;
        logic       todTriggerSel;
        logic       groupLeaderSelect;
        logic       leaderTiming;
        logic [7:0] gpio0Func;
        logic       gpio0OeB;
        logic [7:0] gpio1Func;
        logic       gpio1OeB;
        logic [7:0] pulseCount;
        logic [7:0] pauseCount;
    } srta_trig_cfg_t;

    typedef struct packed {
        logic       internalFeedback;
        logic [7:0] fbPhase;
        logic [7:0] sysrefPhase;
        logic [7:0] devPhase;
        logic [7:0] chanPhase;
    } srta_phase_cfg_t;

endpackage

/* File: design/srta_sysref_trigger.sv */
`timescale 1ns/1ns
`default_nettype none
`include "srta_params.svh"
// Function
// - Internal feedback: sync feedback and output dividers.
// - External feedback: feedback divider idle, outputs synced.
// - Feedback matches reference; edges align when locked.
// - First edges after sync coincide by default.
// - All clocks coincide every Nth cycle.
// - Device clock phase adjustable from 0 to 255 system clock cycles.
// - Channel offset shifts SYSREF and device clocks.
// - Non-leader never drives trigger output pin.
// - Timing 0: start on second SYSREF edge.
// - Timing 1: start on first SYSREF edge.
// - Trigger input pin needs function and disable.
// - Leader drives follower triggers on output pin.
// - Leader accepts register or pin asynchronous triggers.
// - Leader trigger serves itself and followers.
// - Mode 4 pin rise starts counted event.
// - Only whole 50/50 SYSREF cycles are emitted.
module srta_sysref_trigger
    import srta_pkg::*;
#(
    parameter int FB_HALF = `SRTA_FB_HALF_DEF,
    parameter int SR_HALF = `SRTA_SR_HALF_DEF,
    parameter int DC_HALF = `SRTA_DC_HALF_DEF
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    // Configuration and control
    input  wire srta_trig_cfg_t  trigCfg,
    input  wire srta_phase_cfg_t phaseCfg,
    input  wire logic            divSyncReq,
    input  wire logic            initSysref,
    input  wire logic            todCompareEvt,
    // Pins
    input  wire logic            refClkPin,
    input  wire logic            gpio1In,
    // Clocks and trigger out
    output logic                 loopFeedbackClock,
    output logic                 sysrefOut,
    output logic                 internalConverterClock,
    output logic                 fbRefAligned,
    output logic                 gpio0Out,
    output logic                 gpio0Oe,
    output logic                 eventActive
);

    localparam int CNT_W = 16;

    initial begin
        if (FB_HALF < 1 || SR_HALF < 1 || DC_HALF < 1 ||
            FB_HALF >= (1 << CNT_W) || SR_HALF >= (1 << CNT_W) ||
            DC_HALF >= (1 << CNT_W)) begin
            $error("srta_sysref_trigger: half period out of range");
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] refSync_reg;
    logic [1:0] gpSync_reg;
    logic       refLast_reg;
    logic       gpLast_reg;
    logic       initLast_reg;
    logic       todLast_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refSync_reg  <= 2'h0;
            gpSync_reg   <= 2'h0;
            refLast_reg  <= 1'h0;
            gpLast_reg   <= 1'h0;
            initLast_reg <= 1'h0;
            todLast_reg  <= 1'h0;
        end else begin
            refSync_reg  <= {refSync_reg[0], refClkPin};
            gpSync_reg   <= {gpSync_reg[0], gpio1In};
            refLast_reg  <= refSync_reg[1];
            gpLast_reg   <= gpSync_reg[1];
            initLast_reg <= initSysref;
            todLast_reg  <= todCompareEvt;
        end
    end

    // ------------------------------------------------------------------
    // Divider bank
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] halfPer [3];
    logic [CNT_W-1:0] delay   [3];
    logic [2:0]       clkRun;
    logic [2:0]       clkLvl_reg;
    logic [2:0]       clkNext;
    logic [2:0]       clkRise;

    assign halfPer[`SRTA_IDX_FB] = CNT_W'(FB_HALF);
    assign halfPer[`SRTA_IDX_SR] = CNT_W'(SR_HALF);
    assign halfPer[`SRTA_IDX_DC] = CNT_W'(DC_HALF);
    assign delay[`SRTA_IDX_FB] = CNT_W'(phaseCfg.fbPhase);
    assign delay[`SRTA_IDX_SR] = CNT_W'(phaseCfg.sysrefPhase) +
                                 CNT_W'(phaseCfg.chanPhase);
    assign delay[`SRTA_IDX_DC] = CNT_W'(phaseCfg.devPhase) +
                                 CNT_W'(phaseCfg.chanPhase);
    assign clkRun[`SRTA_IDX_FB] = phaseCfg.internalFeedback;
    assign clkRun[`SRTA_IDX_SR] = 1'h1;
    assign clkRun[`SRTA_IDX_DC] = 1'h1;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_div
            logic [CNT_W-1:0] cnt_reg;
            logic [CNT_W-1:0] wait_reg;
            logic             tick;
            assign tick = clkRun[gi] && wait_reg == '0 &&
                          cnt_reg == halfPer[gi] - CNT_W'(1);
            assign clkNext[gi] = tick ? ~clkLvl_reg[gi] : clkLvl_reg[gi];
            assign clkRise[gi] = tick && !clkLvl_reg[gi];
            // One sync request restarts every divider from a common
            // instant, so edges line up first and every Nth cycle.
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_reg        <= '0;
                    wait_reg       <= '0;
                    clkLvl_reg[gi] <= 1'h0;
                end else if (divSyncReq || !clkRun[gi]) begin
                    cnt_reg        <= halfPer[gi] - CNT_W'(1);
                    wait_reg       <= delay[gi];
                    clkLvl_reg[gi] <= 1'h0;
                end else if (wait_reg != '0) begin
                    wait_reg <= wait_reg - CNT_W'(1);
                end else begin
                    cnt_reg        <= tick ? '0 : cnt_reg + CNT_W'(1);
                    clkLvl_reg[gi] <= clkNext[gi];
                end
            end
        end
    endgenerate

    // Feedback edge against reference edge, meaningful once locked.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fbRefAligned <= 1'h0;
        end else if (clkRise[`SRTA_IDX_FB]) begin
            fbRefAligned <= refSync_reg[1] && !refLast_reg;
        end
    end

    // ------------------------------------------------------------------
    // Trigger decode
    // ------------------------------------------------------------------
    logic pinEn;
    logic gpRise;
    logic gpFall;
    logic initRise;
    logic initFall;
    logic todRise;
    logic todFall;
    logic startTrig;
    logic stopTrig;
    logic counted;
    logic pulsePause;
    logic leaderEn;

    assign pinEn = trigCfg.gpio1Func == `SRTA_GPIO_FUNC_TRIG_IN &&
                   trigCfg.gpio1OeB == `SRTA_OE_B_OFF;
    assign gpRise   = pinEn && gpSync_reg[1] && !gpLast_reg;
    assign gpFall   = pinEn && !gpSync_reg[1] && gpLast_reg;
    assign initRise = initSysref && !initLast_reg;
    assign initFall = !initSysref && initLast_reg;
    assign todRise  = todCompareEvt && !todLast_reg;
    assign todFall  = !todCompareEvt && todLast_reg;
    assign leaderEn = trigCfg.groupLeaderSelect == `SRTA_LEADER_ON &&
                      trigCfg.gpio0Func == `SRTA_GPIO_FUNC_TRIG_OUT &&
                      trigCfg.gpio0OeB == `SRTA_OE_B_OFF;

    always_comb begin
        startTrig  = 1'h0;
        stopTrig   = 1'h0;
        counted    = 1'h0;
        pulsePause = 1'h0;
        case (trigCfg.sysrefMode)
            `SRTA_MODE_CNT_REG: begin
                startTrig = initRise;
                counted   = 1'h1;
            end
            `SRTA_MODE_PP_REG: begin
                startTrig  = initRise;
                stopTrig   = initFall;
                pulsePause = 1'h1;
            end
            `SRTA_MODE_CONT_REG: begin
                startTrig = initRise;
                stopTrig  = initFall;
            end
            `SRTA_MODE_CNT_RISE: begin
                startTrig = trigCfg.todTriggerSel ? todRise : gpRise;
                counted   = 1'h1;
            end
            `SRTA_MODE_CNT_FALL: begin
                startTrig = !trigCfg.todTriggerSel && gpFall;
                counted   = 1'h1;
            end
            `SRTA_MODE_CONT_RISE: begin
                startTrig = trigCfg.todTriggerSel ? todRise : gpRise;
                stopTrig  = trigCfg.todTriggerSel ? todFall : gpFall;
            end
            `SRTA_MODE_CONT_FALL: begin
                startTrig = !trigCfg.todTriggerSel && gpFall;
                stopTrig  = !trigCfg.todTriggerSel && gpRise;
            end
            default: begin
                startTrig = 1'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Event sequencer
    // ------------------------------------------------------------------
    srta_state_t state_reg;
    logic [1:0]  edgeCnt_reg;
    logic [7:0]  pulseCnt_reg;
    logic [7:0]  pauseCnt_reg;
    logic        inPause_reg;
    logic        stopPend_reg;
    logic        srEn_reg;
    logic        srRise;
    logic        burstDone;

    assign srRise = clkRise[`SRTA_IDX_SR];
    assign burstDone = pulseCnt_reg >= trigCfg.pulseCount;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= SRTA_IDLE;
            edgeCnt_reg  <= 2'h0;
            pulseCnt_reg <= 8'h0;
            pauseCnt_reg <= 8'h0;
            inPause_reg  <= 1'h0;
            stopPend_reg <= 1'h0;
            srEn_reg     <= 1'h0;
        end else begin
            case (state_reg)
                SRTA_IDLE: begin
                    stopPend_reg <= 1'h0;
                    if (startTrig) begin
                        state_reg   <= SRTA_WAIT;
                        edgeCnt_reg <= (trigCfg.leaderTiming ==
                                        `SRTA_TIMING_SECOND_EDGE) ?
                                       `SRTA_EDGES_SECOND :
                                       `SRTA_EDGES_FIRST;
                    end
                end
                SRTA_WAIT: begin
                    if (stopTrig) begin
                        state_reg <= SRTA_IDLE;
                    end else if (srRise) begin
                        if (edgeCnt_reg == `SRTA_EDGES_FIRST) begin
                            state_reg    <= SRTA_RUN;
                            srEn_reg     <= 1'h1;
                            pulseCnt_reg <= 8'h1;
                            inPause_reg  <= 1'h0;
                        end else begin
                            edgeCnt_reg <= edgeCnt_reg - 2'h1;
                        end
                    end
                end
                SRTA_RUN: begin
                    if (stopTrig) begin
                        stopPend_reg <= 1'h1;
                    end
                    // Enable only moves on a rising edge: whole cycles.
                    if (srRise) begin
                        if (stopPend_reg || stopTrig ||
                            (counted && burstDone)) begin
                            srEn_reg  <= 1'h0;
                            state_reg <= SRTA_IDLE;
                        end else if (!pulsePause) begin
                            pulseCnt_reg <= pulseCnt_reg + 8'h1;
                        end else if (!inPause_reg) begin
                            if (burstDone &&
                                trigCfg.pauseCount != 8'h0) begin
                                inPause_reg  <= 1'h1;
                                srEn_reg     <= 1'h0;
                                pauseCnt_reg <= 8'h1;
                            end else if (burstDone) begin
                                pulseCnt_reg <= 8'h1;
                            end else begin
                                pulseCnt_reg <= pulseCnt_reg + 8'h1;
                            end
                        end else if (pauseCnt_reg >= trigCfg.pauseCount) begin
                            inPause_reg  <= 1'h0;
                            srEn_reg     <= 1'h1;
                            pulseCnt_reg <= 8'h1;
                        end else begin
                            pauseCnt_reg <= pauseCnt_reg + 8'h1;
                        end
                    end
                end
                default: begin
                    state_reg <= SRTA_IDLE;
                    srEn_reg  <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Follower trigger output
    // ------------------------------------------------------------------
    logic trigArm_reg;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            trigArm_reg <= 1'h0;
            gpio0Out    <= 1'h0;
            gpio0Oe     <= 1'h0;
        end else begin
            gpio0Oe <= leaderEn;
            if (!leaderEn) begin
                trigArm_reg <= 1'h0;
                gpio0Out    <= 1'h0;
            end else if (startTrig && state_reg == SRTA_IDLE) begin
                trigArm_reg <= 1'h1;
            end else if (trigArm_reg && srRise) begin
                trigArm_reg <= 1'h0;
                gpio0Out    <= 1'h1;
            end else if (gpio0Out && ((counted && srRise) || stopTrig)) begin
                gpio0Out <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            loopFeedbackClock      <= 1'h0;
            sysrefOut              <= 1'h0;
            internalConverterClock <= 1'h0;
            eventActive            <= 1'h0;
        end else begin
            loopFeedbackClock      <= clkLvl_reg[`SRTA_IDX_FB];
            sysrefOut              <= clkLvl_reg[`SRTA_IDX_SR] && srEn_reg;
            internalConverterClock <= clkLvl_reg[`SRTA_IDX_DC];
            eventActive            <= srEn_reg;
        end
    end

endmodule // srta_sysref_trigger
`default_nettype wire

/* File: bench/srta_far_side.sv */
`timescale 1ns/1ns
`default_nettype none
module srta_far_side #(
    parameter int REF_HALF_NS = 640
) (
    // Bench side
    input  wire logic       clk_sys,
    input  wire logic       pinCmd,
    // Device pins
    input  wire logic       gpio0Out,
    input  wire logic       gpio0Oe,
    output logic            refClkPin,
    output wire logic       gpio1In,
    // Follower status
    output logic [7:0]      trigCount
);
    // ------------------------------------------------------------
    // Reference source and one follower on the group trigger line
    // ------------------------------------------------------------
    logic trigLine;
    logic trigPrev;

    // Reference at feedback rate; its edge meets the final feedback rise.
    initial begin
        refClkPin = 1'b0;
        #360;
        forever #(REF_HALF_NS) refClkPin = ~refClkPin;
    end

    // The trigger pin reaches the device a little after the bench edge.
    assign #3 gpio1In = pinCmd;

    // A released trigger line is pulled low at the follower.
    assign trigLine = gpio0Oe ? gpio0Out : 1'b0;

    // The follower runs a rising-edge mode and takes every rise.
    initial trigCount = 8'h00;
    initial trigPrev = 1'b0;
    always @(posedge clk_sys) begin
        trigPrev <= trigLine;
        if (trigLine && !trigPrev)
            trigCount <= trigCount + 8'h01;
    end
endmodule // srta_far_side
`default_nettype wire

/* File: bench/srta_sysref_trigger_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "srta_params.svh"
module srta_sysref_trigger_asserts
    import srta_pkg::*;
#(
    parameter int FB_HALF = `SRTA_FB_HALF_DEF,
    parameter int SR_HALF = `SRTA_SR_HALF_DEF,
    parameter int DC_HALF = `SRTA_DC_HALF_DEF
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    // Inputs watched
    input  wire srta_trig_cfg_t  trigCfg,
    input  wire srta_phase_cfg_t phaseCfg,
    input  wire logic            divSyncReq,
    input  wire logic            initSysref,
    input  wire logic            gpio1In,
    // Outputs watched
    input  wire logic            loopFeedbackClock,
    input  wire logic            sysrefOut,
    input  wire logic            internalConverterClock,
    input  wire logic            gpio0Out,
    input  wire logic            gpio0Oe,
    input  wire logic            eventActive
);
    // ------------------------------------------------------------
    // Helpers and properties
    // ------------------------------------------------------------
    localparam int FB_PER = 2 * FB_HALF;
    logic [1:0] rstAge;
    logic [5:0] syncAge;
    logic       leaderOn;
    logic       zeroPh;

    assign leaderOn = trigCfg.groupLeaderSelect == `SRTA_LEADER_ON
        && trigCfg.gpio0Func == `SRTA_GPIO_FUNC_TRIG_OUT
        && trigCfg.gpio0OeB == `SRTA_OE_B_OFF;
    assign zeroPh = phaseCfg.fbPhase == 8'h00 && phaseCfg.devPhase == 8'h00
        && phaseCfg.chanPhase == 8'h00;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) rstAge <= 2'h0;
        else if (rstAge != 2'h3) rstAge <= rstAge + 2'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b || divSyncReq) syncAge <= 6'h00;
        else if (syncAge != 6'h3f) syncAge <= syncAge + 6'h01;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_ext_fb_idle;
        !phaseCfg.internalFeedback && !$past(phaseCfg.internalFeedback, 2)
            |-> !loopFeedbackClock;
    endproperty
    a_ext_fb_idle: assert property (p_ext_fb_idle)
        else $error("feedback runs");
    property p_fb_period;
        $rose(loopFeedbackClock) && syncAge == 6'h3f
            |-> $past(loopFeedbackClock, FB_PER)
                && !$past(loopFeedbackClock, FB_PER + 1);
    endproperty
    a_fb_period: assert property (p_fb_period)
        else $error("feedback period");
    property p_edge_coincide;
        $rose(loopFeedbackClock) && zeroPh |-> $rose(internalConverterClock);
    endproperty
    a_edge_coincide: assert property (p_edge_coincide)
        else $error("edges apart");
    property p_no_leader;
        !trigCfg.groupLeaderSelect && !$past(trigCfg.groupLeaderSelect)
            |-> !gpio0Oe;
    endproperty
    a_no_leader: assert property (p_no_leader)
        else $error("follower drives pin");
    property p_leader_oe;
        rstAge == 2'h3 && leaderOn && $past(leaderOn) |-> gpio0Oe;
    endproperty
    a_leader_oe: assert property (p_leader_oe)
        else $error("leader pin off");
    property p_timing0;
        $rose(initSysref) && trigCfg.sysrefMode == `SRTA_MODE_CNT_REG
            && trigCfg.leaderTiming == 1'h0 && !eventActive
            |-> ##1 (!eventActive)[*8] ##1 (!eventActive)[*8]
                ##[1:18] eventActive;
    endproperty
    a_timing0: assert property (p_timing0)
        else $error("second edge start");
    property p_timing1;
        $rose(initSysref) && trigCfg.sysrefMode == `SRTA_MODE_CNT_REG
            && trigCfg.leaderTiming == 1'h1 && !eventActive
            |-> ##[1:19] eventActive;
    endproperty
    a_timing1: assert property (p_timing1)
        else $error("first edge start");
    // The high and low runs below hold for the default SYSREF half period.
    property p_duty;
        $rose(sysrefOut) |-> sysrefOut[*8] ##1 !sysrefOut;
    endproperty
    a_duty: assert property (p_duty)
        else $error("runt high");
    property p_gap;
        $fell(sysrefOut) |-> (!sysrefOut)[*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("runt low");
    property p_leader_lead;
        $rose(gpio0Out) && trigCfg.leaderTiming == `SRTA_TIMING_SECOND_EDGE
            |-> ##[15:17] $rose(eventActive);
    endproperty
    a_leader_lead: assert property (p_leader_lead)
        else $error("lead");
    property p_pin_refused;
        $rose(gpio1In) && trigCfg.sysrefMode == `SRTA_MODE_CNT_RISE
            && trigCfg.gpio1Func != `SRTA_GPIO_FUNC_TRIG_IN && !eventActive
            |-> ##1 (!eventActive)[*8] ##1 (!eventActive)[*8];
    endproperty
    a_pin_refused: assert property (p_pin_refused)
        else $error("pin taken");
endmodule // srta_sysref_trigger_asserts

bind srta_sysref_trigger srta_sysref_trigger_asserts #(
    .FB_HALF(FB_HALF), .SR_HALF(SR_HALF), .DC_HALF(DC_HALF)
) u_chk (
    .clk_sys, .rst_b, .trigCfg, .phaseCfg, .divSyncReq, .initSysref,
    .gpio1In, .loopFeedbackClock, .sysrefOut, .internalConverterClock,
    .gpio0Out, .gpio0Oe, .eventActive
);
`default_nettype wire

/* File: bench/srta_sysref_trigger_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module srta_sysref_trigger_tb
    import srta_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, measurement and tests
    // ------------------------------------------------------------
    localparam int SR_HALF = 8;
    logic            clk_sys = 1'b0;
    logic            rst_b = 1'b0;
    srta_trig_cfg_t  trigCfg;
    srta_phase_cfg_t phaseCfg;
    srta_phase_cfg_t ph;
    logic            divSyncReq = 1'b0;
    logic            initSysref = 1'b0;
    logic            todCompareEvt = 1'b0;
    logic            pinCmd = 1'b0;
    logic            refClkPin;
    wire logic       gpio1In;
    logic            loopFeedbackClock, sysrefOut, internalConverterClock;
    logic            fbRefAligned, gpio0Out, gpio0Oe, eventActive;
    logic [7:0]      trigCount;
    logic            srPrev = 1'b0;
    int              fails = 0;
    int              samplesChecked = 0;
    int              pulseCnt = 0;
    int              cycles = 0;
    int              lat, lat0, np, f0, d0, f1, d1, k;

    srta_sysref_trigger #(.FB_HALF(16), .SR_HALF(SR_HALF), .DC_HALF(2)) DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .trigCfg(trigCfg),
        .phaseCfg(phaseCfg), .divSyncReq(divSyncReq),
        .initSysref(initSysref), .todCompareEvt(todCompareEvt),
        .refClkPin(refClkPin), .gpio1In(gpio1In),
        .loopFeedbackClock(loopFeedbackClock), .sysrefOut(sysrefOut),
        .internalConverterClock(internalConverterClock),
        .fbRefAligned(fbRefAligned), .gpio0Out(gpio0Out),
        .gpio0Oe(gpio0Oe), .eventActive(eventActive));
    srta_far_side #(.REF_HALF_NS(640)) u_far (
        .clk_sys(clk_sys), .pinCmd(pinCmd), .gpio0Out(gpio0Out),
        .gpio0Oe(gpio0Oe), .refClkPin(refClkPin), .gpio1In(gpio1In),
        .trigCount(trigCount));

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        srPrev <= sysrefOut;
        if (sysrefOut === 1'b1 && srPrev === 1'b0) pulseCnt++;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            completeRun();
        end
    end

    task automatic completeRun();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic drive(input int src, input logic v);
        case (src)
            0: initSysref <= v;
            1: pinCmd <= v;
            default: todCompareEvt <= v;
        endcase
    endtask
    // Resyncs the dividers and times the first feedback and clock rises.
    task automatic edges(input srta_phase_cfg_t p, output int f, output int d);
        logic pf, pd;
        phaseCfg <= p;
        divSyncReq <= 1'b1;
        cyc(2);
        divSyncReq <= 1'b0;
        f = -1;
        d = -1;
        pf = 1'b1;
        pd = 1'b1;
        for (int n = 0; n < 100; n++) begin
            cyc(1);
            if (f < 0 && loopFeedbackClock === 1'b1 && pf === 1'b0) f = n;
            if (d < 0 && internalConverterClock === 1'b1 && pd === 1'b0) d = n;
            pf = loopFeedbackClock;
            pd = internalConverterClock;
        end
    endtask
    // Fires one trigger at a fixed feedback phase; returns latency, pulses.
    task automatic run(input logic [2:0] md, input int src, input logic tm,
                       input int hold, output int lt, output int pulses);
        trigCfg.sysrefMode <= md;
        trigCfg.todTriggerSel <= (src == 2);
        trigCfg.leaderTiming <= tm;
        @(posedge loopFeedbackClock);
        cyc(3);
        drive(src, 1'b1);
        pulseCnt = 0;
        lt = 0;
        while (eventActive !== 1'b1 && lt < 200) begin
            cyc(1);
            lt++;
        end
        for (int i = 0; i < 400 && eventActive === 1'b1; i++) begin
            if (i == hold) drive(src, 1'b0);
            cyc(1);
        end
        cyc(1);
        drive(src, 1'b0);
        cyc(20);
        pulses = pulseCnt;
    endtask

    initial begin
        trigCfg = '0;
        trigCfg.gpio0Func = 8'h22;
        trigCfg.gpio0OeB = 1'b1;
        trigCfg.gpio1OeB = 1'b1;
        trigCfg.pulseCount = 8'h03;
        trigCfg.pauseCount = 8'h02;
        phaseCfg = '0;
        phaseCfg.internalFeedback = 1'b1;
        ph = phaseCfg;
        cyc(3);
        check({gpio0Oe, gpio0Out, sysrefOut, eventActive}, 4'h0);
        rst_b <= 1'b1;
        cyc(4);
        $display("test reset done");
        edges(ph, f0, d0);
        check(f0 == -1, 0);
        check(f0, d0);
        ph.devPhase = 8'h02;
        ph.chanPhase = 8'h03;
        edges(ph, f1, d1);
        check(d1 - d0, 5);
        check(f1, f0);
        ph = '0;
        edges(ph, f1, d1);
        check(f1, -1);
        check(d1 == -1, 0);
        ph.internalFeedback = 1'b1;
        edges(ph, f1, d1);
        check(fbRefAligned, 1'b1);
        $display("test dividers done");
        trigCfg.groupLeaderSelect <= 1'b1;
        run(3'h0, 0, 1'b0, 5, lat0, np);
        check(np, 3);
        check(gpio0Oe, 1'b1);
        run(3'h0, 0, 1'b1, 5, lat, np);
        check(lat0 - lat, 2 * SR_HALF);
        check(trigCount, 8'h02);
        $display("test register trigger done");
        run(3'h4, 1, 1'b0, 5, lat, np);
        check(np, 0);
        trigCfg.gpio1Func <= 8'h21;
        run(3'h4, 1, 1'b0, 5, lat, np);
        check(np, 3);
        $display("test pin trigger done");
        for (k = 0; k < 3; k++) begin
            run((k == 0) ? 3'h2 : 3'h6, k, 1'b0, 60, lat, np);
            check(np > 2, 1);
            check(eventActive, 1'b0);
        end
        check(trigCount, 8'h06);
        $display("test continuous done");
        trigCfg.groupLeaderSelect <= 1'b0;
        run(3'h0, 0, 1'b0, 5, lat, np);
        check(np, 3);
        check(gpio0Oe, 1'b0);
        check(trigCount, 8'h06);
        $display("test follower done");
        completeRun();
    end
endmodule // srta_sysref_trigger_tb
`default_nettype wire
